// [line_timing_consts.svh]
`ifndef LINE_TIMING_CONSTS_SVH
`define LINE_TIMING_CONSTS_SVH
// Register offsets
`define OFS_WIN_END_HIGH   8'h13
`define OFS_WIN_END_LOW    8'h14
`define OFS_FLAG_MODE      8'h15
`define OFS_HSYNC_POS      8'h16
// Reset values
`define RST_WIN_END_HIGH   8'h00
`define RST_WIN_END_LOW    8'h00
`define RST_FLAG_MODE      8'h01
`define RST_HSYNC_POS      8'h80
// Field positions
`define FV_CTRL_HI         5
`define FV_CTRL_LO         4
`define SC_RTC_SEL         2
`define SC_RTC_EN          0
// Sync code settings and timing counts in pixel clocks
`define HSYNC_ZERO_CODE    8'h80
`define HSYNC_STEP_SHIFT   2
`define NTSC_BLANK_TO_SYNC 11'd28
`define PAL_BLANK_TO_SYNC  11'd32
`define NTSC_HBLANK_LEN    11'd272
`define PAL_HBLANK_LEN     11'd284
`define NTSC_LINE_LEN      11'd1716
`define PAL_LINE_LEN       11'd1728
`define HSYNC_WIDTH        11'd128
`endif

// [line_timing_pkg.sv]
package line_timing_pkg;
  // Subcarrier output modes
  typedef enum logic [1:0] {SC_GENLOCK, SC_RTC0, SC_RTC1} sc_mode_e;
  // F/V flag modes
  typedef enum logic [1:0] {FV_EVEN_ODD, FV_TOGGLE, FV_PULSE, FV_ILLEGAL} fv_mode_e;
  // Register bus request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  // Timing flags toward the output port
  typedef struct packed {
    logic hsync;
    logic hblank;
    logic active;
    logic eav;
    logic f_bit;
    logic v_bit;
  } line_flags_s;
endpackage

// [video_line_timing_control.sv]
`timescale 1ns/100ps
`include "line_timing_consts.svh"
module video_line_timing_control
  import line_timing_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Register access port
  input  wire reg_req_s    reg_req,
  output logic [7:0]       reg_rdata,
  // Video context from the decoder core
  input  wire logic        pix_en,
  input  wire logic        pal_mode,
  input  wire logic        line_start,
  input  wire logic        field_start,
  input  wire logic        field_odd,
  input  wire logic        in_vblank,
  input  wire logic        std_lines,
  input  wire logic        odd_line_count,
  // Timing outputs
  output line_flags_s      flags,
  output sc_mode_e         sc_mode,
  output fv_mode_e         fv_mode,
  output logic [10:0]      active_end_pos
);

  // Register storage
  // The high byte is only a holding register; the working offset moves
  // on the low-byte write alone, so a half-written value never reaches
  // the timing logic
  // Reserved bits are not stored in the low byte and are masked to 0 on write in the mode byte, which is why they read back 0
  logic [7:0] win_end_high_reg;      // Bits 9:2 of pending offset
  logic [1:0] win_end_low_reg;       // Bits 1:0; upper bits reserved
  logic [9:0] win_end_active_reg;    // Committed working offset
  logic [7:0] flag_mode_reg;         // F/V and subcarrier control
  logic [7:0] hsync_pos_reg;         // Sync position code
  logic [10:0] pix_cnt_reg;          // Pixel position in line
  logic        f_toggle_reg;         // Toggling F state
  logic        f_pulse_reg;          // Pulse-mode F state

  // Address decode
  // Writes to any other offset are ignored
  // Back-to-back writes are fine; each strobe is taken on its own edge
  // Reads take no strobe; the read mux follows the address every clock
  wire wr_high = reg_req.wr && reg_req.addr == `OFS_WIN_END_HIGH;
  wire wr_low  = reg_req.wr && reg_req.addr == `OFS_WIN_END_LOW;
  wire wr_flag = reg_req.wr && reg_req.addr == `OFS_FLAG_MODE;
  wire wr_hpos = reg_req.wr && reg_req.addr == `OFS_HSYNC_POS;

  // Standard-dependent line figures
  // PAL and SECAM share one set; pal_mode covers both
  // Counts are in pixel clocks from the start of the digital line
  wire [10:0] line_len   = pal_mode ? `PAL_LINE_LEN : `NTSC_LINE_LEN;
  wire [10:0] hblank_len = pal_mode ? `PAL_HBLANK_LEN : `NTSC_HBLANK_LEN;
  wire [10:0] sync_base  = pal_mode ? `PAL_BLANK_TO_SYNC : `NTSC_BLANK_TO_SYNC;

  // Default window end is the line length, where the next blanking begins
  // Signed offset widened to 11 bits and added to default end
  wire [10:0] end_ofs_ext = {win_end_active_reg[9], win_end_active_reg};
  wire [10:0] end_pos     = line_len + end_ofs_ext;
  // Same sum in 12 bits: a positive offset can pass 2047 and must not wrap
  wire [11:0] line_len_w  = {1'b0, line_len};
  wire [11:0] end_ofs_w   = {{2{win_end_active_reg[9]}}, win_end_active_reg};
  wire [11:0] end_sum     = line_len_w + end_ofs_w;
  // End code position folded back into the line; a window that runs past
  // the line end puts its end code early in the next line
  wire [11:0] end_fold    = (end_sum >= line_len_w) ? end_sum - line_len_w : end_sum;
  wire [10:0] eav_at      = end_fold[10:0];
  // Counter widened for the window compare
  wire [11:0] pix_cnt_w   = {1'b0, pix_cnt_reg};

  // Sync shift: delay for codes below 0x80, advance above
  // Nine bits hold the signed step count, from -127 up to +128 at code 0x00;
  // four clocks a step keeps the shift inside +/-512, well within 11 bits
  wire [8:0]  code_diff   = {1'b0, `HSYNC_ZERO_CODE} - {1'b0, hsync_pos_reg};
  wire [10:0] shift_clks  = {code_diff[8], code_diff[8], code_diff}
                            << `HSYNC_STEP_SHIFT;
  wire [10:0] sync_raw    = sync_base + shift_clks;
  // Wrap into the line either direction
  // A large advance lands near the end of the previous line
  wire [10:0] sync_start  = sync_raw[10] ? sync_raw + line_len :
                            (sync_raw >= line_len ? sync_raw - line_len : sync_raw);
  // Pulse width is fixed; a pulse over the line end wraps too
  wire [10:0] sync_end_r  = sync_start + `HSYNC_WIDTH;
  wire [10:0] sync_end    = sync_end_r >= line_len ? sync_end_r - line_len : sync_end_r;
  wire        sync_wraps  = sync_end < sync_start;
  wire        sync_now    = sync_wraps ? (pix_cnt_reg >= sync_start || pix_cnt_reg < sync_end)
                                       : (pix_cnt_reg >= sync_start && pix_cnt_reg < sync_end);

  // Mode decode
  // Bit 1 of the subcarrier field is stored but has no effect
  // FV code 11 is illegal; it passes through and the host must avoid it
  wire [1:0] fv_field = {flag_mode_reg[`FV_CTRL_HI], flag_mode_reg[`FV_CTRL_LO]};
  wire sc_next_rtc0 = flag_mode_reg[`SC_RTC_EN] && !flag_mode_reg[`SC_RTC_SEL];
  wire sc_next_rtc1 = flag_mode_reg[`SC_RTC_EN] && flag_mode_reg[`SC_RTC_SEL];
  wire sc_mode_next_bit = sc_next_rtc0 | sc_next_rtc1;

  // F bit selection for nonstandard line counts
  // Standard line counts ignore the field and follow the decoder's field bit
  // Pulse mode holds F high for the first line of each field
  wire f_nonstd = (fv_field == 2'b00) ? (odd_line_count ? f_toggle_reg : 1'b1) :
                  (fv_field == 2'b01) ? f_toggle_reg : f_pulse_reg;
  wire f_next   = std_lines ? field_odd : f_nonstd;
  // V follows the blanking interval; nonstandard line counts take in_vblank unchanged too
  wire v_next   = in_vblank;

  // Register writes; high byte alone leaves working offset untouched
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      win_end_high_reg   <= `RST_WIN_END_HIGH;
      win_end_low_reg    <= 2'b00;
      win_end_active_reg <= 10'h000;
      flag_mode_reg      <= `RST_FLAG_MODE;
      hsync_pos_reg      <= `RST_HSYNC_POS;
    end else begin
      if (wr_high) begin
        win_end_high_reg <= reg_req.wdata;
      end
      if (wr_low) begin
        // Commit: the pending high byte and these two bits go live together
        win_end_low_reg    <= reg_req.wdata[1:0];
        win_end_active_reg <= {win_end_high_reg, reg_req.wdata[1:0]};
      end
      if (wr_flag) begin
        // Reserved bits 7:6 and 3 are dropped and read back as 0
        flag_mode_reg <= reg_req.wdata & 8'h37;
      end
      if (wr_hpos) begin
        hsync_pos_reg <= reg_req.wdata;
      end
    end
  end

  // Read mux registered so the port comes from a flip-flop
  // One-cycle read latency is the price of a glitch-free read port
  // Unmapped offsets read 0
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_req.addr)
        `OFS_WIN_END_HIGH: reg_rdata <= win_end_high_reg;
        `OFS_WIN_END_LOW:  reg_rdata <= {6'b00_0000, win_end_low_reg};
        `OFS_FLAG_MODE:    reg_rdata <= flag_mode_reg;
        `OFS_HSYNC_POS:    reg_rdata <= hsync_pos_reg;
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  // Pixel counter; line_start realigns it
  // It also wraps by itself, so a missed line strobe costs one line at most
  // Counter and flags stand still while pix_en is low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pix_cnt_reg <= 11'h000;
    end else if (pix_en) begin
      if (line_start || pix_cnt_reg >= line_len - 11'd1) begin
        pix_cnt_reg <= 11'h000;
      end else begin
        pix_cnt_reg <= pix_cnt_reg + 11'd1;
      end
    end
  end

  // F state: toggle each field, pulse for one line at field start
  // A new field wins over the line strobe that ends a pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      f_toggle_reg <= 1'b0;
      f_pulse_reg  <= 1'b0;
    end else if (pix_en) begin
      if (field_start) begin
        f_toggle_reg <= ~f_toggle_reg;
      end
      if (field_start) begin
        f_pulse_reg <= 1'b1;
      end else if (line_start) begin
        f_pulse_reg <= 1'b0;
      end
    end
  end

  // Timing flag outputs; end code marks the moved window end
  // Mode outputs follow their registers every clock
  // Flags move only on pix_en, one pixel after the count they decode
  // Reset value of the end position assumes NTSC until the first clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags          <= '0;
      active_end_pos <= `NTSC_LINE_LEN;
      sc_mode        <= SC_RTC0;
      fv_mode        <= FV_EVEN_ODD;
    end else begin
      active_end_pos <= end_pos;
      sc_mode        <= !sc_mode_next_bit ? SC_GENLOCK :
                        (sc_next_rtc1 ? SC_RTC1 : SC_RTC0);
      fv_mode        <= fv_mode_e'(fv_field);
      if (pix_en) begin
        flags.hsync  <= sync_now;
        flags.hblank <= pix_cnt_reg < hblank_len;
        // Active window ends at the line end if the offset pushes it past
        flags.active <= pix_cnt_reg >= hblank_len && pix_cnt_w < end_sum;
        flags.eav    <= pix_cnt_reg == eav_at;
        flags.f_bit  <= f_next;
        flags.v_bit  <= v_next;
      end
    end
  end

endmodule // video_line_timing_control

// [line_timing_monitor.sv]
`timescale 1ns/100ps
module line_timing_monitor
  import line_timing_pkg::*;
(
  // Clock, reset and register port
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire reg_req_s    reg_req,
  input wire logic [7:0]  reg_rdata,
  // Timing side
  input wire logic        pix_en,
  input wire line_flags_s flags,
  input wire sc_mode_e    sc_mode,
  input wire fv_mode_e    fv_mode,
  input wire logic [10:0] active_end_pos
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire lo_wr = reg_req.wr && reg_req.addr == 8'h14; // Commit strobe
  wire md_wr = reg_req.wr && reg_req.addr == 8'h15; // Mode write
  // Write, then the same offset held for readback
  sequence s_rdback(a);
    reg_req.wr && reg_req.addr == a ##1 !reg_req.wr && reg_req.addr == a;
  endsequence
  a_hi_hold: assert property (!lo_wr |-> ##2 $stable(active_end_pos))
    else $error("end position moved without low write");
  a_lo_read: assert property (s_rdback(8'h14) |=>
    reg_rdata == {6'h00, $past(reg_req.wdata[1:0], 2)}) else $error("low byte readback");
  a_hi_read: assert property (s_rdback(8'h13) |=> reg_rdata == $past(reg_req.wdata, 2))
    else $error("high byte readback");
  a_sync_read: assert property (s_rdback(8'h16) |=> reg_rdata == $past(reg_req.wdata, 2))
    else $error("sync code readback");
  a_sc_genlock: assert property (md_wr && !reg_req.wdata[0] |-> ##2 sc_mode == SC_GENLOCK)
    else $error("genlock mode not selected");
  a_sc_rtc: assert property (md_wr && reg_req.wdata[0] |-> ##2
    sc_mode == ($past(reg_req.wdata[2], 2) ? SC_RTC1 : SC_RTC0)) else $error("rtc mode wrong");
  a_fv_select: assert property (md_wr |-> ##2 fv_mode == $past(reg_req.wdata[5:4], 2))
    else $error("flag mode wrong");
  a_unmapped_zero: assert property (reg_req.addr < 8'h13 || reg_req.addr > 8'h16 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_flags_hold: assert property (!pix_en |=> $stable(flags))
    else $error("flags moved without pixel strobe");
endmodule // line_timing_monitor
bind video_line_timing_control line_timing_monitor line_timing_monitor_i (.ref_clk, .rst_n,
  .reg_req, .reg_rdata, .pix_en, .flags, .sc_mode, .fv_mode, .active_end_pos);

// [video_sink.sv]
`timescale 1ns/100ps
module video_sink
  import line_timing_pkg::*;
(
  // Clock and line strobes
  input  wire logic        ref_clk,
  input  wire logic        pix_en,
  input  wire logic        line_start,
  // Flags from the block
  input  wire line_flags_s flags,
  // Measured positions
  output logic [10:0]      eav_pos,
  output logic [10:0]      hs_pos
);
  logic [10:0] cnt  = 11'h000; // Pixels since line start
  logic        ls_d  = 1'b0;   // Line strobe, one pixel late
  logic        eav_d = 1'b0;   // Edge detector, end code
  logic        hs_d  = 1'b0;   // Edge detector, sync
  // Note where codes land; only rising edges count
  // Flags come one register stage after the strobe, so the count restarts a pixel late
  always @(posedge ref_clk) if (pix_en) begin
    ls_d  <= line_start;
    cnt   <= ls_d ? 11'h000 : cnt + 11'h001;
    eav_d <= flags.eav;
    hs_d  <= flags.hsync;
    if (flags.eav && !eav_d) eav_pos <= cnt;
    if (flags.hsync && !hs_d) hs_pos <= cnt;
  end
endmodule // video_sink

// [video_line_timing_control_test.sv]
`timescale 1ns/100ps
`include "line_timing_consts.svh"
module video_line_timing_control_test;
  import line_timing_pkg::*;
  logic        ref_clk = 0, rst_n = 0, line_start = 0, field_odd = 0;
  logic        pix_en = 1, std_lines = 1;
  reg_req_s    reg_req = '0;
  logic [7:0]  reg_rdata, d;
  line_flags_s flags;
  sc_mode_e    sc_mode;
  fv_mode_e    fv_mode;
  logic [10:0] active_end_pos, eav_pos, hs_pos, e0, pcnt = 0;
  int          num_errors = 0, n_checks = 0;
  always #10 ref_clk = ~ref_clk;
  // Free-running NTSC line, one pixel a clock
  always @(negedge ref_clk) begin
    pcnt       <= (pcnt == 11'd1715) ? 11'd0 : pcnt + 11'd1;
    line_start <= (pcnt == 11'd1715);
    if (pcnt == 11'd1715) field_odd <= ~field_odd;
  end
  video_line_timing_control video_line_timing_control_i (.ref_clk, .rst_n, .reg_req,
    .reg_rdata, .pix_en, .pal_mode(1'b0), .line_start, .field_start(line_start),
    .field_odd, .in_vblank(1'b0), .std_lines, .odd_line_count(1'b0), .flags,
    .sc_mode, .fv_mode, .active_end_pos);
  video_sink video_sink_i (.ref_clk, .pix_en, .line_start, .flags, .eav_pos, .hs_pos);
  task automatic chk(input logic [10:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(negedge ref_clk) reg_req <= '{1'b1, a, v};
    @(negedge ref_clk) reg_req.wr <= 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge ref_clk) reg_req <= '{1'b0, a, 8'h00};
    @(negedge ref_clk) chk({3'h0, reg_rdata}, {3'h0, exp});
  endtask
  task automatic t_reset;
    rd(`OFS_WIN_END_HIGH, `RST_WIN_END_HIGH);
    rd(`OFS_WIN_END_LOW, `RST_WIN_END_LOW);
    rd(`OFS_FLAG_MODE, `RST_FLAG_MODE);
    rd(`OFS_HSYNC_POS, `RST_HSYNC_POS);
    rd(8'h17, 8'h00);
    chk(active_end_pos, `NTSC_LINE_LEN);
  endtask
  task automatic t_commit;
    wr(8'h13, 8'h01);
    chk(active_end_pos, `NTSC_LINE_LEN);
    wr(8'h14, 8'hFC);
    chk(active_end_pos, `NTSC_LINE_LEN + 11'd4);
    rd(8'h14, 8'h00);
    wr(8'h13, 8'h80); wr(8'h14, 8'h00);
    chk(active_end_pos, `NTSC_LINE_LEN - 11'd512);
    wr(8'h13, 8'h7F);
    wr(8'h14, 8'h02);
    chk(active_end_pos, `NTSC_LINE_LEN + 11'd510);
  endtask
  task automatic t_eav;
    wr(8'h13, 8'h00); wr(8'h14, 8'h00);
    repeat (3432) @(negedge ref_clk);
    e0 = eav_pos;
    wr(8'h13, 8'hFF); wr(8'h14, 8'h00);
    repeat (3432) @(negedge ref_clk);
    chk(eav_pos, (e0 < 11'd4) ? e0 + `NTSC_LINE_LEN - 11'd4 : e0 - 11'd4);
    chk(active_end_pos, `NTSC_LINE_LEN - 11'd4);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 8; i++) begin
      d = {2'b00, i[1:0], 1'b0, i[1], i[0], i[2]};
      wr(8'h15, d);
      chk({9'h000, fv_mode}, {9'h000, i[1:0]});
      chk({9'h000, sc_mode}, {9'h000, (!i[2] ? SC_GENLOCK : (i[1] ? SC_RTC1 : SC_RTC0))});
      rd(8'h15, d & 8'h37);
    end
  endtask
  task automatic t_hsync;
    repeat (3432) @(negedge ref_clk);
    chk(hs_pos, `NTSC_BLANK_TO_SYNC);
    wr(8'h16, 8'h7E);
    repeat (3432) @(negedge ref_clk);
    chk(hs_pos, `NTSC_BLANK_TO_SYNC + 11'd8);
    wr(8'h16, 8'h81);
    repeat (3432) @(negedge ref_clk);
    chk(hs_pos, `NTSC_BLANK_TO_SYNC - 11'd4);
  endtask
  // Drop the pixel strobe just before blanking ends; flags must freeze
  task automatic t_pause;
    line_flags_s f0;
    for (int i = 0; i < 1716 && pcnt != 11'd270; i++) @(negedge ref_clk);
    chk(pcnt, 11'd270);
    pix_en <= 1'b0;
    f0 = flags;
    repeat (4) @(negedge ref_clk);
    chk({5'h00, flags}, {5'h00, f0});
    pix_en <= 1'b1;
  endtask
  // Nonstandard count in even/odd mode forces F high; standard follows field
  task automatic t_fbit;
    std_lines <= 1'b0;
    wr(`OFS_FLAG_MODE, 8'h01);
    repeat (1716) @(negedge ref_clk);
    chk({10'h000, flags.f_bit}, 11'h001);
    repeat (1716) @(negedge ref_clk);
    chk({10'h000, flags.f_bit}, 11'h001);
    std_lines <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({10'h000, flags.f_bit}, {10'h000, field_odd});
    repeat (1716) @(negedge ref_clk);
    chk({10'h000, flags.f_bit}, {10'h000, field_odd});
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    rst_n = 1;
    t_reset();
    t_commit();
    t_eav();
    t_pause();
    t_modes();
    t_fbit();
    t_hsync();
    end_sim();
  end
endmodule // video_line_timing_control_test
